// >>> rtl/monitor_adc_defines.svh
// constants for the monitoring converter sequencer
`ifndef MONITOR_ADC_DEFINES_SVH
`define MONITOR_ADC_DEFINES_SVH

// channel count and result width
`define ADC_CHANNELS       7
`define ADC_CHAN_W         3
`define ADC_RESULT_W       16

// sample-resolution field encodings
`define ADC_SAMPLE_LONG    2'h0
`define ADC_SAMPLE_MID     2'h1
`define ADC_SAMPLE_SHORT   2'h2

// per-channel conversion times in milliseconds
`define ADC_TCONV_LONG_MS  24
`define ADC_TCONV_MID_MS   12
`define ADC_TCONV_SHORT_MS 6

// clock period in nanoseconds and the derived cycle count of a time in ms
`define ADC_CLK_PERIOD_NS  4
`define ADC_MS_TO_CYCLES(ms) (((ms) * 1000000) / `ADC_CLK_PERIOD_NS)

// width of the conversion timer counter
`define ADC_TIMER_W        23

// reset value of every result word
`define ADC_RESULT_RESET   16'h0000

`endif

// >>> rtl/monitor_adc_pkg.sv
// types shared by the monitoring converter sequencer
`include "monitor_adc_defines.svh"

package monitor_adc_pkg;

    // sequencer states, gray along idle -> convert -> paused
    typedef enum logic [1:0]
    {
        ST_IDLE    = 2'b00,
        ST_CONVERT = 2'b01,
        ST_PAUSED  = 2'b11
    } seq_state_t;

    // one result word
    typedef logic [`ADC_RESULT_W-1:0] result_t;

    // status levels arriving from the analog side of the charger
    typedef struct packed
    {
        logic inputAbove;       // input rail above convert-enable threshold
        logic batteryAbove;     // battery above undervoltage release threshold
        logic isolation;        // input isolation mode active
        logic modeChange;       // charger mode change in progress
        logic adapterPresent;   // adapter plugged in
        logic regulatorReady;   // gate regulator enabled from the input rail
    } pin_status_t;

    // request towards the converter core
    typedef struct packed
    {
        logic                  start;    // one-cycle start of a channel
        logic                  abort;    // one-cycle abort of the running channel
        logic [`ADC_CHAN_W-1:0] channel; // channel being converted
        logic [1:0]            sample;   // resolution setting in use
    } conv_req_t;

endpackage : monitor_adc_pkg

// >>> rtl/conv_timer.sv
// conversion-time down counter with start, abort and done pulse
`timescale 1ns/1ps
`include "monitor_adc_defines.svh"

module conv_timer #(
    parameter int unsigned CNT_W = `ADC_TIMER_W
)(
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             start,     // load length and run
    input  wire logic             abort,     // drop the running count
    input  wire logic [CNT_W-1:0] length,    // cycles per conversion, at least one
    output logic                  done,      // one-cycle pulse, length+1 cycles after start
    output logic                  busy       // counting
);

    logic [CNT_W-1:0] cnt_q;    // cycles left
    logic [CNT_W-1:0] cnt_d;
    logic             busy_q;   // running
    logic             busy_d;
    logic             done_q;   // end pulse
    logic             done_d;

    // next count: start beats abort so a restart after an abort is never lost
    always_comb
    begin
        cnt_d  = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (start)
        begin
            cnt_d  = length;
            busy_d = 1'b1;
        end
        else if (abort)
        begin
            busy_d = 1'b0;   // a stale end pulse is also suppressed
        end
        else if (busy_q)
        begin
            if (cnt_q <= CNT_W'(1))
            begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end
            else
            begin
                cnt_d = cnt_q - CNT_W'(1);
            end
        end
    end

    // registers only
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign done = done_q;
    assign busy = busy_q;

endmodule : conv_timer

// >>> rtl/monitor_adc_sequencer.sv
// channel sequencer and result store of the monitoring converter
//
// Contract
// - seven channels, each with own enable bit
// - one bit picks continuous or one-shot
// - continuous mode cycles enabled channels forever
// - one-shot runs one pass, then clears enable
// - convert only with run enable and channel enable, except a resume from pause
// - no channel enabled clears run enable at once
// - no valid supply: no conversion, enable cleared
// - mode change aborts, resume at same channel
// - resolution field sets per-channel conversion time
// - results keep last value, zero from reset
// - channel disabled mid-conversion finishes, then skipped
// - idle stays ready, starts when host sets run enable with a channel enabled
// - faults do not stop; host must clear
// - plug-in pauses until gate regulator is up
// - host clear stops at once, results kept
// - switch to one-shot ends after full cycle
// - all channels cleared ends after current channel
// - battery-only running powers up the regulator
// - watchdog expiry clears run enable
`timescale 1ns/1ps
`include "monitor_adc_defines.svh"

module monitor_adc_sequencer #(
    parameter int unsigned NCH          = `ADC_CHANNELS,
    parameter int unsigned TW           = `ADC_TIMER_W,
    parameter int unsigned LONG_CYCLES  = `ADC_MS_TO_CYCLES(`ADC_TCONV_LONG_MS),
    parameter int unsigned MID_CYCLES   = `ADC_MS_TO_CYCLES(`ADC_TCONV_MID_MS),
    parameter int unsigned SHORT_CYCLES = `ADC_MS_TO_CYCLES(`ADC_TCONV_SHORT_MS)
)(
    input  wire logic                           clk,
    input  wire logic                           reset,
    input  wire logic [NCH-1:0]                 chanEnable,      // low bits of converter_option_register
    input  wire logic                           rateContinuous,  // 1 continuous, 0 one-shot
    input  wire logic [1:0]                     sampleSel,       // resolution and conversion time
    input  wire logic                           convEnableSet,   // host writes conversion_enable to 1
    input  wire logic                           convEnableClear, // host writes conversion_enable to 0
    input  wire logic                           watchdogExpired, // watchdog expiry pulse
    input  wire monitor_adc_pkg::pin_status_t   pinStatus,       // asynchronous analog status levels
    input  wire monitor_adc_pkg::result_t       sampleData,      // converter core output word
    output monitor_adc_pkg::conv_req_t          convReq,         // request to the converter core
    output logic                                convEnable,      // conversion_enable read-back
    output logic                                seqBusy,         // a channel is converting or paused
    output logic                                regulatorPowerUp, // request internal_gate_regulator on
    output monitor_adc_pkg::result_t [NCH-1:0]  results          // last valid result per channel
);

    localparam logic [`ADC_CHAN_W-1:0] LAST_CH = `ADC_CHAN_W'(NCH - 1);

    // two-stage synchroniser for the analog status levels
    monitor_adc_pkg::pin_status_t syncA_q;    // first stage, read only by syncB_q
    monitor_adc_pkg::pin_status_t syncB_q;    // safe copy
    logic                         plugPrev_q; // adapter level one cycle back

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            syncA_q    <= '0;
            syncB_q    <= '0;
            plugPrev_q <= 1'b0;
        end
        else
        begin
            syncA_q    <= pinStatus;
            syncB_q    <= syncA_q;
            plugPrev_q <= syncB_q.adapterPresent;
        end
    end

    // derived conditions
    logic supplyOk;   // either rail good enough to measure
    logic plugEdge;   // adapter just arrived
    logic anyEn;      // at least one channel enabled
    logic hostStop;   // reasons to stop immediately

    assign supplyOk = syncB_q.inputAbove | syncB_q.batteryAbove;
    assign plugEdge = syncB_q.adapterPresent & ~plugPrev_q;
    assign anyEn    = |chanEnable;
    // fault inputs are deliberately absent: only the host, the watchdog and the supply stop a run
    assign hostStop = convEnableClear | watchdogExpired | ~supplyOk;

    // lowest enabled channel strictly above cur, or lowest overall when wrap is set
    function automatic logic [`ADC_CHAN_W:0] pick_next(
        input logic [NCH-1:0]         mask,
        input logic [`ADC_CHAN_W-1:0] cur,
        input logic                   wrap
    );
        logic [`ADC_CHAN_W:0] res;
        res = '0;
        for (int i = NCH - 1; i >= 0; i--)
        begin
            if (mask[i] && (wrap || (`ADC_CHAN_W'(i) > cur)))
            begin
                res = {1'b1, `ADC_CHAN_W'(i)};
            end
        end
        return res;
    endfunction : pick_next

    // sequencer state
    monitor_adc_pkg::seq_state_t  state_q;
    monitor_adc_pkg::seq_state_t  state_d;
    logic [`ADC_CHAN_W-1:0]       chan_q;     // channel converting or interrupted
    logic [`ADC_CHAN_W-1:0]       chan_d;
    logic                         convEn_q;   // conversion_enable
    logic                         convEn_d;
    logic                         plugWait_q; // paused by plug-in, regulator needed
    logic                         plugWait_d;
    monitor_adc_pkg::conv_req_t   req_q;
    monitor_adc_pkg::conv_req_t   req_d;
    logic                         busy_q;
    logic                         busy_d;
    logic                         regUp_q;
    logic                         regUp_d;
    logic                         startNow;   // timer starts this cycle, core request one cycle later
    logic                         abortNow;   // running channel dropped this cycle
    logic                         passEnd;    // one-shot pass just finished
    logic                         timerDone;  // channel conversion finished
    logic [`ADC_CHAN_W:0]         firstEn;    // lowest enabled channel
    logic [`ADC_CHAN_W:0]         higherEn;   // next enabled channel above chan_q
    logic [TW-1:0]                convLen;    // cycles per channel for this setting

    assign firstEn  = pick_next(chanEnable, '0, 1'b1);
    assign higherEn = pick_next(chanEnable, chan_q, 1'b0);

    // conversion time follows the resolution setting; unknown codes take the shortest
    always_comb
    begin
        case (sampleSel)
            `ADC_SAMPLE_LONG: convLen = TW'(LONG_CYCLES);
            `ADC_SAMPLE_MID:  convLen = TW'(MID_CYCLES);
            default:          convLen = TW'(SHORT_CYCLES);
        endcase
    end

    // next state, channel and run enable
    always_comb
    begin
        state_d    = state_q;
        chan_d     = chan_q;
        plugWait_d = plugWait_q | plugEdge;
        startNow   = 1'b0;
        abortNow   = 1'b0;
        passEnd    = 1'b0;
        case (state_q)
            monitor_adc_pkg::ST_IDLE:
            begin
                // stays powered and ready; starts as soon as run enable is set with a channel enabled
                if (convEn_q && anyEn && !hostStop && !syncB_q.modeChange && !plugEdge)
                begin
                    chan_d   = firstEn[`ADC_CHAN_W-1:0];
                    startNow = 1'b1;
                    state_d  = monitor_adc_pkg::ST_CONVERT;
                end
                plugWait_d = 1'b0;
            end
            monitor_adc_pkg::ST_CONVERT:
            begin
                if (hostStop)
                begin
                    abortNow = 1'b1;
                    state_d  = monitor_adc_pkg::ST_IDLE;
                end
                else if (syncB_q.modeChange || plugEdge)
                begin
                    abortNow = 1'b1;
                    state_d  = monitor_adc_pkg::ST_PAUSED;
                end
                else if (timerDone)
                begin
                    if (!convEn_q)
                    begin
                        state_d = monitor_adc_pkg::ST_IDLE;
                    end
                    else if (higherEn[`ADC_CHAN_W])
                    begin
                        chan_d   = higherEn[`ADC_CHAN_W-1:0];
                        startNow = 1'b1;
                    end
                    else if (rateContinuous)
                    begin
                        chan_d   = firstEn[`ADC_CHAN_W-1:0];
                        startNow = 1'b1;
                    end
                    else
                    begin
                        passEnd = 1'b1;
                        state_d = monitor_adc_pkg::ST_IDLE;
                    end
                end
            end
            monitor_adc_pkg::ST_PAUSED:
            begin
                if (hostStop)
                begin
                    state_d = monitor_adc_pkg::ST_IDLE;
                end
                else if (!syncB_q.modeChange && !plugEdge && (!plugWait_q || syncB_q.regulatorReady))
                begin
                    startNow   = 1'b1;
                    plugWait_d = 1'b0;
                    state_d    = monitor_adc_pkg::ST_CONVERT;
                end
            end
            default:
            begin
                state_d = monitor_adc_pkg::ST_IDLE;
            end
        endcase

        // run enable: host set survives the pass end, hard clears win
        convEn_d = convEn_q | convEnableSet;
        if (passEnd)
        begin
            convEn_d = convEnableSet;
        end
        if (convEnableClear || watchdogExpired || !supplyOk || !anyEn)
        begin
            convEn_d = 1'b0;
        end

        req_d.start   = startNow;
        req_d.abort   = abortNow;
        req_d.channel = chan_d;
        req_d.sample  = sampleSel;
        busy_d        = (state_d != monitor_adc_pkg::ST_IDLE);
        // battery-only or isolated running draws the regulator up whenever conversion is enabled
        regUp_d       = convEn_d & (~syncB_q.inputAbove | syncB_q.isolation);
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_q    <= monitor_adc_pkg::ST_IDLE;
            chan_q     <= '0;
            convEn_q   <= 1'b0;
            plugWait_q <= 1'b0;
            req_q      <= '0;
            busy_q     <= 1'b0;
            regUp_q    <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            chan_q     <= chan_d;
            convEn_q   <= convEn_d;
            plugWait_q <= plugWait_d;
            req_q      <= req_d;
            busy_q     <= busy_d;
            regUp_q    <= regUp_d;
        end
    end

    // per-channel conversion timer
    conv_timer #(
        .CNT_W (TW)
    ) u_timer (
        .clk    (clk),
        .reset  (reset),
        .start  (startNow),
        .abort  (abortNow),
        .length (convLen),
        .done   (timerDone),
        .busy   ()
    );

    // result store: one word per channel, whole word written only at a clean end
    monitor_adc_pkg::result_t [NCH-1:0] res_q;
    monitor_adc_pkg::result_t [NCH-1:0] res_d;
    logic                               resWrite;   // the finished word is valid

    assign resWrite = (state_q == monitor_adc_pkg::ST_CONVERT) & timerDone & ~hostStop
                      & ~syncB_q.modeChange & ~plugEdge;

    for (genvar g = 0; g < NCH; g++)
    begin : g_result
        always_comb
        begin
            res_d[g] = res_q[g];
            if (resWrite && (chan_q == `ADC_CHAN_W'(g)))
            begin
                res_d[g] = sampleData;
            end
        end

        always_ff @(posedge clk)
        begin
            if (reset)
            begin
                res_q[g] <= `ADC_RESULT_RESET;
            end
            else
            begin
                res_q[g] <= res_d[g];
            end
        end
    end

    assign convReq          = req_q;
    assign convEnable       = convEn_q;
    assign seqBusy          = busy_q;
    assign regulatorPowerUp = regUp_q;
    assign results          = res_q;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_pass_end;
        (state_q == monitor_adc_pkg::ST_CONVERT) && timerDone && !hostStop && !syncB_q.modeChange
        && !plugEdge && convEn_q && !higherEn[`ADC_CHAN_W] && !rateContinuous && !convEnableSet;
    endsequence

    property p_no_chan;
        !anyEn |=> !convEn_q;
    endproperty
    a_no_chan: assert property (p_no_chan) else $error("run enable kept with no channel");

    property p_supply;
        !supplyOk |=> !convEn_q && (state_q == monitor_adc_pkg::ST_IDLE);
    endproperty
    a_supply: assert property (p_supply) else $error("converting without valid supply");

    property p_host_stop;
        convEnableClear |=> (state_q == monitor_adc_pkg::ST_IDLE) && !convEn_q && $stable(res_q);
    endproperty
    a_host_stop: assert property (p_host_stop) else $error("host clear did not stop");

    property p_watchdog;
        watchdogExpired |=> !convEn_q;
    endproperty
    a_watchdog: assert property (p_watchdog) else $error("watchdog did not clear enable");

    property p_pass_end;
        s_pass_end |=> !convEn_q ##1 (state_q == monitor_adc_pkg::ST_IDLE) && !convReq.start;
    endproperty
    a_pass_end: assert property (p_pass_end) else $error("one-shot did not end");

    property p_start_enabled;
        startNow && (state_q == monitor_adc_pkg::ST_IDLE) |-> chanEnable[chan_d] && convEn_q;
    endproperty
    a_start_enabled: assert property (p_start_enabled) else $error("start on disabled channel");

    property p_results_hold;
        !resWrite |=> $stable(res_q);
    endproperty
    a_results_hold: assert property (p_results_hold) else $error("result changed without conversion");

    property p_resume_same;
        (state_q == monitor_adc_pkg::ST_PAUSED) |=> $stable(chan_q);
    endproperty
    a_resume_same: assert property (p_resume_same) else $error("channel moved while paused");

    property p_plug_wait;
        (state_q == monitor_adc_pkg::ST_PAUSED) && plugWait_q && !syncB_q.regulatorReady
        |=> state_q != monitor_adc_pkg::ST_CONVERT;
    endproperty
    a_plug_wait: assert property (p_plug_wait) else $error("resumed before regulator ready");

endmodule : monitor_adc_sequencer

// >>> verif/conv_core_model.sv
// converter core stand-in that answers each channel start with a tagged word
`timescale 1ns/1ps
module conv_core_model (
    input  wire logic                       clk,
    input  wire logic                       reset,
    input  wire monitor_adc_pkg::conv_req_t req,
    input  wire logic [7:0]                 tag,
    output monitor_adc_pkg::result_t        sampleData
);
    logic       live_q; // a channel was started and not aborted since
    logic [2:0] chan_q; // channel under conversion
    logic [7:0] cyc_q;  // free counter for the idle pattern
    // latch the channel on start, drop the word on abort
    always_ff @(posedge clk)
    begin
        cyc_q <= reset ? 8'h00 : cyc_q + 8'h01;
        if (reset)
        begin
            live_q <= 1'b0;
        end
        else if (req.start)
        begin
            live_q <= 1'b1;
            chan_q <= req.channel;
        end
        else if (req.abort)
        begin
            live_q <= 1'b0;
        end
    end
    // after reset or an abort the word churns, so a stray capture cannot look valid; after a clean end it keeps the tagged word
    assign sampleData = live_q ? {4'h5, 1'b0, chan_q, tag} : {cyc_q, ~cyc_q};
endmodule : conv_core_model

// >>> verif/monitor_adc_sequencer_tb.sv
// self-checking bench of the monitoring converter sequencer
`timescale 1ns/1ps
module monitor_adc_sequencer_tb;
    localparam int LC = 20; // shortened conversion lengths
    localparam int MC = 10;
    localparam int SC = 5;
    logic                               clk;
    logic                               reset;
    logic [6:0]                         chanEnable;
    logic                               rateContinuous;
    logic [1:0]                         sampleSel;
    logic                               convEnableSet;
    logic                               convEnableClear;
    logic                               watchdogExpired;
    monitor_adc_pkg::pin_status_t       pinStatus;
    monitor_adc_pkg::result_t           sampleData;
    monitor_adc_pkg::conv_req_t         convReq;
    logic                               convEnable;
    logic                               seqBusy;
    logic                               regulatorPowerUp;
    monitor_adc_pkg::result_t [6:0]     results;
    logic [7:0]                         tag;   // word marker served by the core model
    int                                 error_cnt;
    int                                 tests_run;
    int                                 gap;   // cycles between two starts
    monitor_adc_sequencer #(.LONG_CYCLES(LC), .MID_CYCLES(MC), .SHORT_CYCLES(SC)) uut (
        .clk(clk), .reset(reset), .chanEnable(chanEnable), .rateContinuous(rateContinuous),
        .sampleSel(sampleSel), .convEnableSet(convEnableSet), .convEnableClear(convEnableClear),
        .watchdogExpired(watchdogExpired), .pinStatus(pinStatus), .sampleData(sampleData),
        .convReq(convReq), .convEnable(convEnable), .seqBusy(seqBusy),
        .regulatorPowerUp(regulatorPowerUp), .results(results));
    conv_core_model core (.clk(clk), .reset(reset), .req(convReq), .tag(tag), .sampleData(sampleData));
    // free-running clock
    always #2 clk = ~clk;
    function automatic logic [15:0] word(input logic [2:0] ch, input logic [7:0] t);
        return {4'h5, 1'b0, ch, t};
    endfunction : word
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task wrap_up;
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    // wait n edges, then let that edge's updates settle
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // one-cycle host pulses, lowered at the following edge
    task pulse(input logic s, input logic c, input logic w);
        @(posedge clk);
        convEnableSet   <= s;
        convEnableClear <= c;
        watchdogExpired <= w;
        @(posedge clk);
        convEnableSet   <= 1'b0;
        convEnableClear <= 1'b0;
        watchdogExpired <= 1'b0;
    endtask : pulse
    task run(input logic [6:0] ch, input logic cont, input logic [1:0] sel, input logic [7:0] t);
        @(posedge clk);
        chanEnable     <= ch;
        rateContinuous <= cont;
        sampleSel      <= sel;
        tag            <= t;
        pulse(1'b1, 1'b0, 1'b0);
    endtask : run
    // bounded wait for the next start, which must name channel ch
    task waitStart(input logic [2:0] ch);
        gap = 0;
        do
        begin
            tick(1);
            gap++;
        end
        while (convReq.start !== 1'b1 && gap < 200);
        if (gap >= 200)
        begin
            chk(16'h0bad, 16'h0000);
            wrap_up();
        end
        chk(16'(convReq.channel), 16'(ch));
    endtask : waitStart
    task waitIdle;
        int n;
        n = 0;
        while (seqBusy !== 1'b0 && n < 400)
        begin
            tick(1);
            n++;
        end
        if (n >= 400)
        begin
            chk(16'h0bad, 16'h0001);
            wrap_up();
        end
    endtask : waitIdle
    task scRefuse;
        for (int i = 0; i < 7; i++)
            chk(results[i], 16'h0000);
        run(7'h00, 1'b0, 2'h2, 8'h00);
        tick(2);
        chk(16'(convEnable), 16'h0000);
        pinStatus.inputAbove   <= 1'b0;
        pinStatus.batteryAbove <= 1'b0;
        tick(4);
        run(7'h01, 1'b0, 2'h2, 8'h00);
        tick(3);
        chk(16'(convEnable), 16'h0000);
        chk(16'(seqBusy), 16'h0000);
        pinStatus.inputAbove   <= 1'b1;
        pinStatus.batteryAbove <= 1'b1;
        tick(4);
    endtask : scRefuse
    // one-shot passes over channels 0 and 6 at every resolution code
    task scOneShot;
        int len;
        for (int s = 0; s < 4; s++)
        begin
            len = (s == 0) ? LC : (s == 1) ? MC : SC;
            run(7'h41, 1'b0, 2'(s), 8'(8'h10 + s));
            waitStart(3'h0);
            chk(16'(convReq.sample), 16'(s));
            waitStart(3'h6);
            chk(16'(gap >= len && gap <= len + 2), 16'h0001);
            waitIdle();
            chk(16'(convEnable), 16'h0000);
            chk(results[0], word(3'h0, 8'(8'h10 + s)));
            chk(results[6], word(3'h6, 8'(8'h10 + s)));
            chk(results[3], 16'h0000);
        end
    endtask : scOneShot
    task scContinuous;
        run(7'h0a, 1'b1, 2'h2, 8'h3c);
        waitStart(3'h1);
        waitStart(3'h3);
        waitStart(3'h1);
        @(posedge clk);
        rateContinuous <= 1'b0;
        waitStart(3'h3);
        waitIdle();
        tick(3 * SC);
        chk(16'(seqBusy), 16'h0000);
        chk(results[1], word(3'h1, 8'h3c));
        pulse(1'b0, 1'b1, 1'b0);
    endtask : scContinuous
    // host clear in mid conversion keeps the older word
    task scClear;
        run(7'h08, 1'b1, 2'h0, 8'h77);
        waitStart(3'h3);
        tick(4);
        pulse(1'b0, 1'b1, 1'b0);
        tick(2);
        chk(16'(convEnable), 16'h0000);
        chk(16'(seqBusy), 16'h0000);
        tick(LC);
        chk(results[3], word(3'h3, 8'h3c));
    endtask : scClear
    // mode change and plug-in pauses resume on the interrupted channel
    task scPause;
        run(7'h32, 1'b1, 2'h1, 8'h99);
        waitStart(3'h1);
        waitStart(3'h4);
        tick(2);
        pinStatus.modeChange <= 1'b1;
        tick(MC + 4);
        chk(16'(seqBusy), 16'h0001);
        chk(results[4], 16'h0000);
        pinStatus.modeChange <= 1'b0;
        waitStart(3'h4);
        tick(2);
        pinStatus.adapterPresent <= 1'b1;
        pinStatus.regulatorReady <= 1'b0;
        tick(MC + 4);
        chk(results[4], 16'h0000);
        pinStatus.regulatorReady <= 1'b1;
        waitStart(3'h4);
        waitStart(3'h5);
        chk(results[4], word(3'h4, 8'h99));
        pulse(1'b0, 1'b1, 1'b0);
        tick(2);
    endtask : scPause
    // all channels dropped: enable clears, the running channel still lands
    task scDisable;
        run(7'h60, 1'b1, 2'h2, 8'h5a);
        waitStart(3'h5);
        @(posedge clk);
        chanEnable <= 7'h00;
        tick(2);
        chk(16'(convEnable), 16'h0000);
        waitIdle();
        chk(results[5], word(3'h5, 8'h5a));
        chk(results[6], word(3'h6, 8'h13));
    endtask : scDisable
    // battery-only running asks for the regulator; watchdog stops it
    task scBattery;
        pinStatus.inputAbove <= 1'b0;
        tick(4);
        run(7'h01, 1'b1, 2'h0, 8'h00);
        tick(3);
        chk(16'(convEnable), 16'h0001);
        chk(16'(regulatorPowerUp), 16'h0001);
        pulse(1'b0, 1'b0, 1'b1);
        tick(2);
        chk(16'(convEnable), 16'h0000);
        tick(2);
        chk(16'(regulatorPowerUp), 16'h0000);
    endtask : scBattery
    // main sequence
    initial
    begin
        error_cnt = 0;
        tests_run = 0;
        clk = 1'b0;
        reset = 1'b1;
        chanEnable = 7'h00;
        rateContinuous = 1'b0;
        sampleSel = 2'h0;
        convEnableSet = 1'b0;
        convEnableClear = 1'b0;
        watchdogExpired = 1'b0;
        pinStatus = 6'h31; // both supplies valid, no mode change, regulator up
        tag = 8'h00;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        tick(3);
        scRefuse();
        scOneShot();
        scContinuous();
        scClear();
        scPause();
        scDisable();
        scBattery();
        wrap_up();
    end
endmodule : monitor_adc_sequencer_tb
